// ===== src/sas_result_mem.sv
// Purpose: per-channel result store of the converter sequencer
// Assumes: one write port from the sequencer, one read port from the bus
// Notes: read data is registered, so it appears one edge after raddr_i
module sas_result_mem #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] rdata_r;

	// one storage word per channel, cleared by reset
	for (genvar g = 0; g < DEPTH; g++)
	begin : g_word
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				mem_r[g] <= '0;
			else if (we_i && (waddr_i == AW'(g)))
				mem_r[g] <= wdata_i;
		end
	end

	// registered read port
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= '0;
		else
			rdata_r <= mem_r[raddr_i];
	end

	assign rdata_o = rdata_r;
endmodule

// ===== src/sas_sar_adc_sequencer.sv
// Purpose: sequencer of a 10-bit successive-approximation converter
// Assumes: classic Wishbone slave, 32-bit data, one 200 MHz clock
// Notes: analog comparator and external trigger arrive asynchronously
//
// How it works
// - successive approximation gives a 10-bit result each conversion
// - start may be set in the same write that changes mode or channel
// - single mode: a start converts the one selected channel once
// - single result lands in the data register of that channel
// - single end sets the end flag; interrupt request if enabled
// - start flag reads 1 during single conversion, cleared at end
// - scan converts a group of at most four channels in turn
// - scan begins on input 0, or input 4 when group select is 1
// - each scanned result is stored as soon as it completes
// - after group's last channel: end flag, request if enabled, restart at first
// - scan never clears start; repeats while set, stops when cleared
// - after start: start delay, then sampling, then conversion
// - start delay is 6 to 9 states, or 4 to 5 at fast speed
// - sampling lasts 31 states, or 15 at fast speed
// - first conversion takes 131 to 134 states, or 69 to 70
// - later scan conversions take 128 states, or 66 at fast speed
// - the trigger pin starts conversion only when trigger enabled
// - enabled trigger falling edge sets the start flag
// - trigger start acts exactly as a software start
// - channel bits: channel in single, group end in scan mode
// - mode bit 0 selects single, 1 selects scan; resets to 0
// - reset or standby clears the start flag and stops scanning
//
// Decided for this implementation: the address map and the Wishbone slave port.
package sas_pkg;
	// register byte addresses
	localparam logic [5:0] ADR_CTRL = 6'h00;
	localparam logic [5:0] ADR_TRIG = 6'h04;
	localparam logic [5:0] ADR_DATA = 6'h20;
	// control/status and trigger field positions
	localparam int CS_END_BIT = 7;
	localparam int CS_IE_BIT = 6;
	localparam int CS_START_BIT = 5;
	localparam int CS_SCAN_BIT = 4;
	localparam int CS_SPEED_BIT = 3;
	localparam int TRG_EN_BIT = 7;
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_TRIG = 8'h7e;
	localparam logic [7:0] TRIG_RSVD_ONES = 8'h7e;
	// timing in states, speed 0 and speed 1
	localparam logic [6:0] DLY_MIN0 = 7'h06;
	localparam logic [6:0] DLY_MIN1 = 7'h04;
	localparam logic [6:0] SPL0 = 7'h1f;
	localparam logic [6:0] SPL1 = 7'h0f;
	localparam logic [6:0] CONV0 = 7'h5e;
	localparam logic [6:0] CONV1 = 7'h32;
	localparam logic [6:0] RESTART0 = 7'h03;
	localparam logic [6:0] RESTART1 = 7'h01;
	localparam logic [3:0] STEP0 = 4'h9;
	localparam logic [3:0] STEP1 = 4'h5;
	localparam int RES_W = 10;
	localparam logic [9:0] SAR_MSB = 10'h200;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_SAMPLE = 4'h4,
		ST_CONV = 4'h8
	} sas_state_t;
endpackage

module sas_sar_adc_sequencer
	import sas_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic standby_i,
	input wire logic ext_trigger_pin_i,
	input wire logic comp_i,
	output logic sample_o,
	output logic [9:0] dac_code_o,
	output logic [2:0] chan_o,
	output logic conversion_end_irq_o
);
	logic ack_r;
	logic pend_r;
	logic [31:0] dat_r;
	logic req;
	logic wr_ctrl;
	logic wr_trig;
	logic trg_s1_r, trg_s2_r, trg_s3_r;
	logic comp_s1_r, comp_s2_r;
	logic trg_fall;
	logic start_flag_r, start_flag_nxt;
	logic end_flag_r, end_flag_nxt;
	logic ie_r, scan_r, speed_r;
	logic [2:0] chsel_r;
	logic trig_en_r, trig_rsvd_r;
	logic irq_r;
	logic [1:0] ph_r;
	sas_state_t st_r;
	logic [6:0] cnt_r;
	logic [3:0] step_r;
	logic [9:0] bit_r, sar_r, dac_r, sar_new;
	logic [2:0] cur_ch_r;
	logic sample_r;
	logic sw_set, sw_clr, trig_set, conv_done, end_evt, sar_take, last_ch;
	logic [6:0] dly_load;
	logic [9:0] mem_rdata;
	logic [7:0] ctrl_rd;

	// bus handshake: request seen, one pending cycle, then ack
	assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~pend_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pend_r <= 1'b0;
			ack_r <= 1'b0;
		end
		else
		begin
			pend_r <= req;
			ack_r <= pend_r & wb_cyc_i & wb_stb_i;
		end
	end

	// writes land on the edge that the master samples ack
	assign wr_ctrl = ack_r & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == ADR_CTRL);
	assign wr_trig = ack_r & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == ADR_TRIG);

	// read data, unmapped addresses read zero
	assign ctrl_rd = {end_flag_r, ie_r, start_flag_r, scan_r, speed_r,
		chsel_r};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= '0;
		else if (pend_r)
		begin
			if (wb_adr_i == ADR_CTRL)
				dat_r <= {24'h000000, ctrl_rd};
			else if (wb_adr_i == ADR_TRIG)
				dat_r <= {24'h000000, trig_en_r, TRIG_RSVD_ONES[6:1],
					trig_rsvd_r};
			else if (wb_adr_i[5] && (wb_adr_i[1:0] == 2'h0))
				dat_r <= {22'h000000, mem_rdata};
			else
				dat_r <= '0;
		end
	end

	// two-flop synchronisers, third stage for trigger edge detection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trg_s1_r <= 1'b1;
			trg_s2_r <= 1'b1;
			trg_s3_r <= 1'b1;
			comp_s1_r <= 1'b0;
			comp_s2_r <= 1'b0;
		end
		else
		begin
			trg_s1_r <= ext_trigger_pin_i;
			trg_s2_r <= trg_s1_r;
			trg_s3_r <= trg_s2_r;
			comp_s1_r <= comp_i;
			comp_s2_r <= comp_s1_r;
		end
	end
	assign trg_fall = trg_s3_r & ~trg_s2_r;

	// start flag sources; a set beats a write or end clear in the same cycle, but standby beats any set
	assign sw_set = wr_ctrl & wb_dat_i[CS_START_BIT];
	assign sw_clr = wr_ctrl & ~wb_dat_i[CS_START_BIT];
	assign trig_set = trig_en_r & trg_fall;
	assign conv_done = (st_r == ST_CONV) && (cnt_r == 7'h00);
	assign last_ch = cur_ch_r == chsel_r;
	assign end_evt = conv_done & (~scan_r | last_ch);

	always_comb
	begin
		start_flag_nxt = start_flag_r;
		if (standby_i)
			start_flag_nxt = 1'b0;
		else if (sw_set | trig_set)
			start_flag_nxt = 1'b1;
		else if (sw_clr | (conv_done & ~scan_r))
			start_flag_nxt = 1'b0;
		end_flag_nxt = end_flag_r;
		if (end_evt)
			end_flag_nxt = 1'b1;
		else if (wr_ctrl & ~wb_dat_i[CS_END_BIT])
			end_flag_nxt = 1'b0;
	end

	// control and trigger registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_flag_r <= RST_CTRL[CS_START_BIT];
			end_flag_r <= RST_CTRL[CS_END_BIT];
			ie_r <= RST_CTRL[CS_IE_BIT];
			scan_r <= RST_CTRL[CS_SCAN_BIT];
			speed_r <= RST_CTRL[CS_SPEED_BIT];
			chsel_r <= RST_CTRL[2:0];
			trig_en_r <= RST_TRIG[TRG_EN_BIT];
			trig_rsvd_r <= RST_TRIG[0];
		end
		else
		begin
			start_flag_r <= start_flag_nxt;
			end_flag_r <= end_flag_nxt;
			if (wr_ctrl)
			begin
				ie_r <= wb_dat_i[CS_IE_BIT];
				scan_r <= wb_dat_i[CS_SCAN_BIT];
				speed_r <= wb_dat_i[CS_SPEED_BIT];
				chsel_r <= wb_dat_i[2:0];
			end
			if (wr_trig)
			begin
				trig_en_r <= wb_dat_i[TRG_EN_BIT];
				trig_rsvd_r <= wb_dat_i[0];
			end
		end
	end

	// interrupt request follows flag and enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= end_flag_r & ie_r;
	end

	// free phase counter, makes start delay depend on write timing
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ph_r <= 2'h0;
		else
			ph_r <= ph_r + 2'h1;
	end
	assign dly_load = speed_r ? (DLY_MIN1 + {6'h00, ph_r[0]})
		: (DLY_MIN0 + {5'h00, ph_r});

	// one approximation step: keep trial bit if input is above code
	assign sar_take = (st_r == ST_CONV) && (step_r == 4'h0) && (bit_r != '0);
	assign sar_new = (sar_take && comp_s2_r) ? dac_r : sar_r;

	// sequencer: idle, start delay, sampling, approximation
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			step_r <= '0;
			bit_r <= '0;
			sar_r <= '0;
			dac_r <= '0;
			cur_ch_r <= '0;
			sample_r <= 1'b0;
		end
		else if (!start_flag_r && st_r != ST_IDLE)
		begin
			st_r <= ST_IDLE;
			sample_r <= 1'b0;
		end
		else
		begin
			unique case (st_r)
				ST_IDLE:
				begin
					if (start_flag_r)
					begin
						st_r <= ST_DELAY;
						cnt_r <= dly_load - 7'h02;
						cur_ch_r <= scan_r ? {chsel_r[2], 2'h0}
							: chsel_r;
					end
				end
				ST_DELAY:
				begin
					if (cnt_r == 7'h00)
					begin
						st_r <= ST_SAMPLE;
						cnt_r <= (speed_r ? SPL1 : SPL0) - 7'h01;
						sample_r <= 1'b1;
					end
					else
						cnt_r <= cnt_r - 7'h01;
				end
				ST_SAMPLE:
				begin
					if (cnt_r == 7'h00)
					begin
						st_r <= ST_CONV;
						cnt_r <= (speed_r ? CONV1 : CONV0) - 7'h01;
						step_r <= (speed_r ? STEP1 : STEP0) - 4'h1;
						bit_r <= SAR_MSB;
						sar_r <= '0;
						dac_r <= SAR_MSB;
						sample_r <= 1'b0;
					end
					else
						cnt_r <= cnt_r - 7'h01;
				end
				ST_CONV:
				begin
					if (sar_take)
					begin
						sar_r <= sar_new;
						bit_r <= bit_r >> 1;
						dac_r <= sar_new | (bit_r >> 1);
						step_r <= (speed_r ? STEP1 : STEP0) - 4'h1;
					end
					else if (step_r != 4'h0)
						step_r <= step_r - 4'h1;
					if (conv_done)
					begin
						if (scan_r)
						begin
							st_r <= ST_DELAY;
							cnt_r <= (speed_r ? RESTART1 : RESTART0) - 7'h01;
							cur_ch_r <= last_ch ? {chsel_r[2], 2'h0}
								: cur_ch_r + 3'h1;
						end
						else
							st_r <= ST_IDLE;
					end
					else
						cnt_r <= cnt_r - 7'h01;
				end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// results go to the store of the channel just converted
	sas_result_mem #(
		.WIDTH(RES_W),
		.DEPTH(8),
		.AW(3)
	) u_mem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(conv_done),
		.waddr_i(cur_ch_r),
		.wdata_i(sar_new),
		.raddr_i(wb_adr_i[4:2]),
		.rdata_o(mem_rdata)
	);

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign sample_o = sample_r;
	assign dac_code_o = dac_r;
	assign chan_o = cur_ch_r;
	assign conversion_end_irq_o = irq_r;

	// checks
	property p_single_clear;
		@(posedge clk_i) disable iff (rst_i)
		conv_done && !scan_r && !sw_set && !trig_set |=> !start_flag_r;
	endproperty
	a_single_clear: assert property (p_single_clear)
		else $error("single end did not clear start flag");

	property p_end_flag;
		@(posedge clk_i) disable iff (rst_i)
		end_evt |=> end_flag_r ##1 (conversion_end_irq_o == ie_r);
	endproperty
	a_end_flag: assert property (p_end_flag)
		else $error("end flag or request missing after conversion end");

	property p_irq_follow;
		@(posedge clk_i) disable iff (rst_i)
		end_flag_r && ie_r |=> conversion_end_irq_o;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("request not raised while flag and enable set");

	// judged where the window closes, so an aborted window is left out
	property p_sample_len0;
		@(posedge clk_i) disable iff (rst_i)
		$fell(sample_o) && !speed_r && start_flag_r
			|-> $past(sample_o, 31) && !$past(sample_o, 32);
	endproperty
	a_sample_len0: assert property (p_sample_len0)
		else $error("sampling window is not 31 states");

	property p_scan_keep;
		@(posedge clk_i) disable iff (rst_i)
		conv_done && scan_r && !sw_clr && !standby_i |=> start_flag_r
			&& st_r == ST_DELAY;
	endproperty
	a_scan_keep: assert property (p_scan_keep)
		else $error("scan cleared start flag or stopped");

	property p_scan_wrap;
		@(posedge clk_i) disable iff (rst_i)
		conv_done && scan_r && last_ch && start_flag_r
			|=> chan_o == {chsel_r[2], 2'h0};
	endproperty
	a_scan_wrap: assert property (p_scan_wrap)
		else $error("scan did not restart at first channel");

	property p_trig_start;
		@(posedge clk_i) disable iff (rst_i)
		trig_en_r && trg_fall && !standby_i |=> start_flag_r;
	endproperty
	a_trig_start: assert property (p_trig_start)
		else $error("enabled trigger edge did not set start flag");

	property p_trig_off;
		@(posedge clk_i) disable iff (rst_i)
		!start_flag_r && !trig_en_r && !sw_set |=> !start_flag_r;
	endproperty
	a_trig_off: assert property (p_trig_off)
		else $error("start flag set without enabled source");

	property p_delay0;
		@(posedge clk_i) disable iff (rst_i)
		st_r == ST_IDLE && start_flag_r && !speed_r
			|-> ##[6:9] (st_r == ST_SAMPLE) or ##[1:9] !start_flag_r;
	endproperty
	a_delay0: assert property (p_delay0)
		else $error("start delay outside 6 to 9 states");
endmodule

// ===== tb/sas_analog_model.sv
// Purpose: far-side model of the analog inputs and the trigger source
// Assumes: each channel holds a fixed level made from its own number
// Notes: comparator answers at once; trigger pin idles high (pull-up)
module sas_analog_model (
	input wire logic clk_i,
	input wire logic [9:0] dac_code_i,
	input wire logic [2:0] chan_i,
	input wire logic trig_req_i,
	output logic comp_o,
	output logic trig_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] level;

	// level of the channel under conversion, compared with the trial code
	assign level = {chan_i, 7'h2b};
	assign comp_o = (level >= dac_code_i);

	// trigger pin pulled low only while the bench asks for a pulse
	always_ff @(posedge clk_i)
	begin
		trig_pin_o <= !trig_req_i;
	end
endmodule

// ===== tb/test_sas_sar_adc_sequencer.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: registered Wishbone ack, analog model on the far side
// Notes: expected results are the model levels {chan, 7'h2b}
module test_sas_sar_adc_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import sas_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, standby = 1'b0, trig_req = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, pin, comp, smp, irq;
	logic [9:0] dac;
	logic [2:0] chan;
	int mismatches = 0, n_checks = 0, n;

	// 200 MHz clock
	always #2.5 clk_i = !clk_i;

	sas_sar_adc_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.standby_i(standby), .ext_trigger_pin_i(pin), .comp_i(comp),
		.sample_o(smp), .dac_code_o(dac), .chan_o(chan),
		.conversion_end_irq_o(irq));
	sas_analog_model model (.clk_i(clk_i), .dac_code_i(dac), .chan_i(chan),
		.trig_req_i(trig_req), .comp_o(comp), .trig_pin_o(pin));

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask

	// one classic cycle; held until ack is sampled high
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (ack !== 1'b1 && i < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20)
		begin
			mismatches++;
			final_report();
		end
	endtask

	// poll the end flag through the bus, bounded
	task wait_end;
		int i;
		i = 0;
		do
		begin
			wb(1'b0, ADR_CTRL, 32'h0);
			i++;
		end
		while (q[7] !== 1'b1 && i < 150);
		if (i >= 150)
		begin
			mismatches++;
			final_report();
		end
	endtask

	task trig_pulse;
		@(posedge clk_i);
		trig_req <= 1'b1;
		repeat (4) @(posedge clk_i);
		trig_req <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask

	task t_reset;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(1'b0, ADR_TRIG, 32'h0);
		chk("trig", q, 32'h7e);
		wb(1'b1, ADR_DATA, 32'h3ff);
		wb(1'b0, ADR_DATA, 32'h0);
		chk("data ro", q, 32'h0);
		wb(1'b0, 6'h08, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("reset test done");
	endtask

	task t_single;
		wb(1'b1, ADR_CTRL, 32'h63);
		n = 0;
		while (irq !== 1'b1 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("single time", 32'(n >= 133 && n <= 136), 32'h1);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("single ctrl", q, 32'hc3);
		wb(1'b0, ADR_DATA + 6'h0c, 32'h0);
		chk("single data", q, {22'h0, 3'h3, 7'h2b});
		chk("irq held", 32'(irq), 32'h1);
		wb(1'b1, ADR_CTRL, 32'h40);
		repeat (3) @(posedge clk_i);
		chk("irq clear", 32'(irq), 32'h0);
		$display("single test done");
	endtask

	task t_scan;
		wb(1'b1, ADR_CTRL, 32'h3d);
		wait_end();
		chk("scan ctrl", q, 32'hbd);
		chk("scan irq", 32'(irq), 32'h0);
		chk("scan wrap", 32'(chan), 32'h4);
		wb(1'b0, ADR_DATA + 6'h10, 32'h0);
		chk("scan d4", q, {22'h0, 3'h4, 7'h2b});
		wb(1'b0, ADR_DATA + 6'h14, 32'h0);
		chk("scan d5", q, {22'h0, 3'h5, 7'h2b});
		// stop first, keeping mode, speed and channel as they are
		wb(1'b1, ADR_CTRL, 32'h1d);
		repeat (150) @(posedge clk_i);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("scan stop", q, 32'h1d);
		$display("scan test done");
	endtask

	task t_trig;
		wb(1'b1, ADR_CTRL, 32'h0a);
		trig_pulse();
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("trig off", q, 32'h0a);
		wb(1'b1, ADR_TRIG, 32'h80);
		trig_pulse();
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("trig busy", q, 32'h2a);
		wait_end();
		chk("trig end", q, 32'h8a);
		wb(1'b0, ADR_DATA + 6'h08, 32'h0);
		chk("trig data", q, {22'h0, 3'h2, 7'h2b});
		wb(1'b1, ADR_TRIG, 32'h0);
		$display("trigger test done");
	endtask

	task t_standby;
		wb(1'b1, ADR_CTRL, 32'h30);
		repeat (20) @(posedge clk_i);
		chk("sampling", 32'(smp), 32'h1);
		chk("scan base", 32'(chan), 32'h0);
		standby <= 1'b1;
		@(posedge clk_i);
		standby <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("standby", q, 32'h10);
		chk("sample off", 32'(smp), 32'h0);
		$display("standby test done");
	endtask

	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_single();
		t_scan();
		t_trig();
		t_standby();
		final_report();
	end
endmodule
